// file: logic/sadc_pkg.sv
// Shared constants and types for the serial converter host interface
package sadc_pkg;

  // ************************************************************
  // Word and field layout
  // ************************************************************
  localparam int FRAME_BITS  = 16;
  localparam int CODE_BITS   = 13;
  localparam int CHAN_COUNT  = 8;
  localparam int FIFO_DEPTH  = 8;
  localparam int TRACK_EDGE  = 14;  // Bit count at the fifteenth falling edge
  localparam int LAST_EDGE   = 15;  // Bit count at the sixteenth falling edge

  // Write word: [15] write, [14:13] target, payload below
  localparam int WR_FLAG_POS   = 15;
  localparam int WR_TGT_LSB    = 13;
  localparam int CHAN_LSB      = 10;
  localparam int CFG_LSB       = 8;
  localparam int CODING_POS    = 7;
  localparam int SEQ_EN_POS    = 6;
  localparam int STBY_POS      = 5;

  localparam logic [1:0] TGT_CONTROL  = 2'h0;
  localparam logic [1:0] TGT_RANGE_LO = 2'h1;
  localparam logic [1:0] TGT_RANGE_HI = 2'h2;
  localparam logic [1:0] TGT_SEQUENCE = 2'h3;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_MHZ   = 250;
  localparam int QUIET_NS  = 50;
  localparam int WAKE_US   = 1;
  localparam int QUIET_CYC = (QUIET_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_CYC  = WAKE_US * CLK_MHZ;

  // ************************************************************
  // Types and reset values
  // ************************************************************
  typedef enum logic [1:0] {
    CFG_SINGLE8 = 2'h0,
    CFG_DIFF4   = 2'h1,
    CFG_PSEUDO4 = 2'h2,
    CFG_PSEUDO7 = 2'h3
  } input_cfg_type;

  typedef struct packed {
    logic [2:0]    channel_address_field;
    input_cfg_type input_config;  // input_config_msb, input_config_lsb
    logic          straight_binary;
    logic          seq_enable;
    logic          auto_standby;
  } ctrl_type;

  typedef struct packed {
    logic [2:0]  channel;
    logic        sign;
    logic [11:0] data;
  } result_type;

  localparam ctrl_type CTRL_RESET = '{3'h0, CFG_SINGLE8, 1'b0, 1'b0, 1'b0};
  localparam logic [15:0] RANGE_RESET = 16'h0000;
  localparam logic [7:0]  SEQ_RESET   = 8'h00;

endpackage : sadc_pkg

// file: logic/sadc_host_if.sv
// Serial host interface, conversion control and result buffer
`timescale 1ns/1ps

// How it works
// - Serial clock times the 16-edge conversion
// - Chip select fall starts frame, and conversion unless buffer full
// - Result bits leave on serial clock falls
// - Word: channel, sign, twelve data bits, MSB first
// - At least 50 ns quiet before next frame
// - Output driven from frame start until edge sixteen
// - Write data captured on serial clock falls
// - Channel address field picks converted channel
// - Two-bit field selects input arrangement
// - Each channel keeps its own input range
// - Multiplexer follows control or sequence selection
// - Auto standby wake within one microsecond
// - Coding bit: one binary, zero two's complement
// - Track resumes after fifteenth falling edge

module sadc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [DEPTH-1:0][WIDTH-1:0] mem;
  logic [DEPTH-1:0][WIDTH-1:0] next_mem;
  logic [AW-1:0]               wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
  logic [AW:0]                 count, next_count;
  logic                        push, pop;

  assign in_ready  = (count != (AW+1)'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (push) begin
      next_mem[wr_ptr] = in_data;
      next_wr_ptr      = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    next_count = count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mem    <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end
endmodule : sadc_fifo

module sadc_host_if (
  // Clock and reset
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  // Serial pins
  input  wire logic                 cs_n,
  input  wire logic                 sclk,
  input  wire logic                 din,
  output logic                      dout,
  output logic                      dout_oe,
  // Analog core
  input  wire logic [12:0]          conv_code,
  output logic                      hold_en,
  output logic [2:0]                mux_sel,
  output logic [1:0]                range_sel,
  output sadc_pkg::input_cfg_type   input_config,
  output logic                      power_up,
  // Status and buffer control
  input  wire logic                 read_hold,
  output logic                      conv_done,
  output logic                      quiet_err,
  output logic                      result_full
);

  // ************************************************************
  // Types and state
  // ************************************************************
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_QUIET  = 3'b100
  } frame_state_type;

  frame_state_type   state, next_state;
  logic              sclk_prev, next_sclk_prev;
  logic              cs_prev, next_cs_prev;
  logic [3:0]        bit_cnt, next_bit_cnt;
  logic [15:0]       out_shift, next_out_shift;
  logic [15:0]       in_shift, next_in_shift;
  logic [7:0]        quiet_cnt, next_quiet_cnt;
  logic [7:0]        wake_cnt, next_wake_cnt;
  logic              conv_act, next_conv_act;
  logic [2:0]        conv_chan, next_conv_chan;
  sadc_pkg::ctrl_type ctrl, next_ctrl;
  logic [15:0]       range_regs, next_range_regs;
  logic [7:0]        seq_mask, next_seq_mask;
  logic [2:0]        seq_chan, next_seq_chan;
  logic              next_dout, next_dout_oe, next_hold_en, next_power_up;
  logic              next_conv_done, next_quiet_err;
  logic [2:0]        next_mux_sel;
  logic [1:0]        next_range_sel;

  // FIFO wiring
  logic              fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
  logic [15:0]       fifo_out_data;
  sadc_pkg::result_type push_word;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [2:0] seq_after(input logic [2:0] cur, input logic [7:0] mask);
    logic [2:0] idx;
    logic       found;
    seq_after = cur;
    found     = 1'b0;
    for (int i = 1; i <= 8; i++) begin
      idx = 3'(cur + 3'(i));
      if (!found && mask[idx]) begin
        seq_after = idx;
        found     = 1'b1;
      end
    end
  endfunction : seq_after

  function automatic logic [1:0] range_of(input logic [15:0] regs, input logic [2:0] ch);
    range_of = regs[{ch, 1'b0} +: 2];
  endfunction : range_of

  wire sclk_fall  = sclk_prev && !sclk;
  wire cs_fall    = cs_prev && !cs_n;
  wire [2:0] sel_chan = ctrl.seq_enable ? seq_chan : ctrl.channel_address_field;

  // ************************************************************
  // Result buffer
  // ************************************************************
  sadc_fifo #(
    .WIDTH (sadc_pkg::FRAME_BITS),
    .DEPTH (sadc_pkg::FIFO_DEPTH)
  ) sadc_fifo_i (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (fifo_in_valid),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  always_comb begin
    push_word.channel = conv_chan;
    push_word.sign    = conv_code[12] ^ ctrl.straight_binary;
    push_word.data    = conv_code[11:0];
  end

  assign fifo_in_valid  = (state == ST_ACTIVE) && sclk_fall && conv_act
                          && (bit_cnt == 4'(sadc_pkg::LAST_EDGE));
  // Holding keeps the head for a re-read; this is what lets the buffer fill
  assign fifo_out_ready = (state == ST_IDLE) && cs_fall && !read_hold;

  // ************************************************************
  // Frame, conversion and register control
  // ************************************************************
  always_comb begin
    next_state      = state;
    next_sclk_prev  = sclk;
    next_cs_prev    = cs_n;
    next_bit_cnt    = bit_cnt;
    next_out_shift  = out_shift;
    next_in_shift   = in_shift;
    next_quiet_cnt  = quiet_cnt;
    next_wake_cnt   = wake_cnt;
    next_conv_act   = conv_act;
    next_conv_chan  = conv_chan;
    next_ctrl       = ctrl;
    next_range_regs = range_regs;
    next_seq_mask   = seq_mask;
    next_seq_chan   = seq_chan;
    next_dout       = dout;
    next_dout_oe    = dout_oe;
    next_hold_en    = hold_en;
    next_power_up   = power_up;
    next_conv_done  = 1'b0;
    next_quiet_err  = 1'b0;
    next_mux_sel    = sel_chan;
    next_range_sel  = range_of(range_regs, sel_chan);

    // Wake from auto standby by a fixed count of core clocks
    if (!power_up && wake_cnt != '0) begin
      next_wake_cnt = wake_cnt - 1'b1;
      if (wake_cnt == 8'h01) begin
        next_power_up = 1'b1;
      end
    end

    case (state)
      ST_IDLE: begin
        if (cs_fall) begin
          next_state     = ST_ACTIVE;
          next_bit_cnt   = '0;
          next_out_shift = fifo_out_valid ? fifo_out_data : 16'h0000;
          next_dout      = fifo_out_valid ? fifo_out_data[15] : 1'b0;
          next_dout_oe   = 1'b1;
          // A full buffer refuses the conversion rather than lose a word
          next_conv_act  = fifo_in_ready;
          next_conv_chan = sel_chan;
          next_hold_en   = fifo_in_ready;
          if (!power_up) begin
            next_wake_cnt = 8'(sadc_pkg::WAKE_CYC);
          end
        end
      end
      ST_ACTIVE: begin
        if (cs_n) begin
          // Early release aborts the frame, nothing is written or stored
          next_state     = ST_QUIET;
          next_dout_oe   = 1'b0;
          next_hold_en   = 1'b0;
          next_conv_act  = 1'b0;
          next_quiet_cnt = 8'(sadc_pkg::QUIET_CYC);
        end else if (sclk_fall) begin
          next_bit_cnt   = bit_cnt + 1'b1;
          next_in_shift  = {in_shift[14:0], din};
          next_out_shift = {out_shift[14:0], 1'b0};
          next_dout      = out_shift[14];
          if (bit_cnt == 4'(sadc_pkg::TRACK_EDGE)) begin
            next_hold_en = 1'b0;
          end
          if (bit_cnt == 4'(sadc_pkg::LAST_EDGE)) begin
            next_state     = ST_QUIET;
            next_dout_oe   = 1'b0;
            next_dout      = 1'b0;
            next_conv_done = conv_act;
            next_conv_act  = 1'b0;
            next_quiet_cnt = 8'(sadc_pkg::QUIET_CYC);
            if (ctrl.seq_enable) begin
              next_seq_chan = seq_after(seq_chan, seq_mask);
            end
            if (ctrl.auto_standby) begin
              next_power_up = 1'b0;
            end
            if (in_shift[sadc_pkg::WR_FLAG_POS-1]) begin
              case (in_shift[sadc_pkg::WR_TGT_LSB-1 +: 2])
                sadc_pkg::TGT_CONTROL: begin
                  next_ctrl.channel_address_field =
                    in_shift[sadc_pkg::CHAN_LSB-1 +: 3];
                  next_ctrl.input_config = sadc_pkg::input_cfg_type'(
                    in_shift[sadc_pkg::CFG_LSB-1 +: 2]);
                  next_ctrl.straight_binary = in_shift[sadc_pkg::CODING_POS-1];
                  next_ctrl.seq_enable   = in_shift[sadc_pkg::SEQ_EN_POS-1];
                  next_ctrl.auto_standby = in_shift[sadc_pkg::STBY_POS-1];
                end
                sadc_pkg::TGT_RANGE_LO: next_range_regs[7:0]  = {in_shift[6:0], din};
                sadc_pkg::TGT_RANGE_HI: next_range_regs[15:8] = {in_shift[6:0], din};
                sadc_pkg::TGT_SEQUENCE: begin
                  next_seq_mask = {in_shift[6:0], din};
                  next_seq_chan = in_shift[sadc_pkg::CHAN_LSB-1 +: 3];
                end
                default: next_seq_mask = seq_mask;
              endcase
            end
          end
        end
      end
      ST_QUIET: begin
        if (quiet_cnt != '0) begin
          next_quiet_cnt = quiet_cnt - 1'b1;
          if (cs_fall) begin
            next_quiet_err = 1'b1;
          end
        end else if (cs_n) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state   = ST_IDLE;
        next_dout_oe = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state        <= ST_IDLE;
      sclk_prev    <= 1'b0;
      cs_prev      <= 1'b1;
      bit_cnt      <= '0;
      out_shift    <= '0;
      in_shift     <= '0;
      quiet_cnt    <= '0;
      wake_cnt     <= '0;
      conv_act     <= 1'b0;
      conv_chan    <= '0;
      ctrl         <= sadc_pkg::CTRL_RESET;
      range_regs   <= sadc_pkg::RANGE_RESET;
      seq_mask     <= sadc_pkg::SEQ_RESET;
      seq_chan     <= '0;
      dout         <= 1'b0;
      dout_oe      <= 1'b0;
      hold_en      <= 1'b0;
      power_up     <= 1'b1;
      conv_done    <= 1'b0;
      quiet_err    <= 1'b0;
      mux_sel      <= '0;
      range_sel    <= '0;
      input_config <= sadc_pkg::CFG_SINGLE8;
      result_full  <= 1'b0;
    end else begin
      state        <= next_state;
      sclk_prev    <= next_sclk_prev;
      cs_prev      <= next_cs_prev;
      bit_cnt      <= next_bit_cnt;
      out_shift    <= next_out_shift;
      in_shift     <= next_in_shift;
      quiet_cnt    <= next_quiet_cnt;
      wake_cnt     <= next_wake_cnt;
      conv_act     <= next_conv_act;
      conv_chan    <= next_conv_chan;
      ctrl         <= next_ctrl;
      range_regs   <= next_range_regs;
      seq_mask     <= next_seq_mask;
      seq_chan     <= next_seq_chan;
      dout         <= next_dout;
      dout_oe      <= next_dout_oe;
      hold_en      <= next_hold_en;
      power_up     <= next_power_up;
      conv_done    <= next_conv_done;
      quiet_err    <= next_quiet_err;
      mux_sel      <= next_mux_sel;
      range_sel    <= next_range_sel;
      input_config <= next_ctrl.input_config;
      result_full  <= !fifo_in_ready;
    end
  end

endmodule : sadc_host_if

// file: dv/sadc_host_if_checker.sv
// Timing checks on the serial pins and conversion control
`timescale 1ns/1ps

module sadc_host_if_checker (
  // Clock and reset
  input wire logic       core_clk,
  input wire logic       rst_n,
  // Serial pins
  input wire logic       cs_n,
  input wire logic       sclk,
  input wire logic       dout,
  input wire logic       dout_oe,
  // Core and status
  input wire logic       hold_en,
  input wire logic [2:0] mux_sel,
  input wire logic       power_up,
  input wire logic       conv_done,
  input wire logic       quiet_err
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // ****
  // Clock falls seen inside a frame
  // ****
  logic       prev_sclk;
  logic [4:0] falls;
  logic [4:0] next_falls;

  always_comb begin
    next_falls = falls;
    if (cs_n) begin
      next_falls = 5'h00;
    end else if (prev_sclk && !sclk) begin
      next_falls = falls + 5'h01;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      prev_sclk <= 1'b1;
      falls     <= 5'h00;
    end else begin
      prev_sclk <= sclk;
      falls     <= next_falls;
    end
  end

  sequence sclk_fell_s;
    $past(sclk, 2) && !$past(sclk);
  endsequence
  sequence cs_fell_s;
    $past(cs_n, 2) && !$past(cs_n);
  endsequence

  start_drive_a: assert property ($rose(dout_oe) |-> cs_fell_s)
    else $error("output enable rose without select fall");
  bit_shift_a: assert property (dout_oe && $past(dout_oe) && $changed(dout) |-> sclk_fell_s)
    else $error("output bit moved without clock fall");
  cs_release_a: assert property (cs_n && $past(cs_n) && $past(cs_n, 2) |-> !dout_oe)
    else $error("output driven while deselected");
  end_release_a: assert property (conv_done |-> !dout_oe && $past(dout_oe))
    else $error("output not released at frame end");
  conv_count_a: assert property (conv_done |-> falls == 5'h10)
    else $error("conversion done not at sixteenth fall");
  hold_start_a: assert property ($rose(hold_en) |-> cs_fell_s)
    else $error("hold began without select fall");
  track_edge_a: assert property ($fell(hold_en) && !cs_n |-> falls == 5'h0f)
    else $error("tracking resumed at wrong fall");
  wake_time_a: assert property (!power_up && $fell(cs_n) |-> ##[1:251] power_up)
    else $error("wake took too long");
  quiet_flag_a: assert property (quiet_err |-> cs_fell_s)
    else $error("quiet fault without select fall");
  quiet_block_a: assert property (quiet_err |-> !dout_oe [*3])
    else $error("frame started inside quiet time");
  mux_steady_a: assert property (hold_en && $past(hold_en) |-> $stable(mux_sel))
    else $error("channel moved during hold");
endmodule : sadc_host_if_checker

// file: dv/sadc_host_model.sv
// Host serial port model: select, clock and write data
`timescale 1ns/1ps

module sadc_host_model (
  // Clock
  input wire logic core_clk,
  // Serial pins
  output logic     cs_n,
  output logic     sclk,
  output logic     din,
  input wire logic dout
);
  // Clock idles high and stands still between frames
  initial begin
    cs_n = 1'b1;
    sclk = 1'b1;
    din  = 1'b0;
  end

  // Fewer than 16 falls makes an aborted frame
  task automatic frame(input logic [15:0] wr, input int nfall, output logic [15:0] rd);
    rd = 16'h0000;
    @(negedge core_clk) cs_n = 1'b0;
    repeat (2) @(negedge core_clk);
    for (int i = 15; i >= 16 - nfall; i--) begin
      din = wr[i];
      repeat (2) @(negedge core_clk);
      rd[i] = dout;
      sclk = 1'b0;
      repeat (2) @(negedge core_clk);
      sclk = 1'b1;
    end
    cs_n = 1'b1;
    din  = ~din;
  endtask : frame

  task automatic pulse(input int n);
    @(negedge core_clk) cs_n = 1'b0;
    repeat (n) @(negedge core_clk);
    cs_n = 1'b1;
  endtask : pulse
endmodule : sadc_host_model

// file: dv/test_sadc_host_if.sv
// Self-checking bench for the serial converter host interface
`timescale 1ns/1ps

module test_sadc_host_if;
  logic                    core_clk = 1'b0;
  logic                    rst_n = 1'b0;
  logic                    read_hold = 1'b0;
  logic [12:0]             conv_code = 13'h0000;
  logic                    cs_n, sclk, din, dout, dout_oe, hold_en, power_up;
  logic                    conv_done, quiet_err, result_full;
  logic [2:0]              mux_sel;
  logic [1:0]              range_sel;
  sadc_pkg::input_cfg_type input_config;
  int                      fails = 0;
  int                      checks_done = 0;
  int                      dones = 0;
  int                      qerrs = 0;
  int                      holds = 0;
  int                      cur_ch = 0;
  logic                    cur_bin = 1'b0;
  logic [15:0]             pend = 16'h0000;
  logic                    pend_ok = 1'b1;

  always #2 core_clk = ~core_clk;

  always @(posedge core_clk) begin
    if (conv_done === 1'b1) dones++;
    if (quiet_err === 1'b1) qerrs++;
    if ($rose(hold_en)) holds++;
  end

  sadc_host_model sadc_host_model_i (.core_clk(core_clk), .cs_n(cs_n), .sclk(sclk), .din(din),
    .dout(dout));

  sadc_host_if sadc_host_if_i (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
    .din(din), .dout(dout), .dout_oe(dout_oe), .conv_code(conv_code), .hold_en(hold_en),
    .mux_sel(mux_sel), .range_sel(range_sel), .input_config(input_config),
    .power_up(power_up), .read_hold(read_hold), .conv_done(conv_done),
    .quiet_err(quiet_err), .result_full(result_full));

  // ****
  // Helpers
  // ****
  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  function automatic logic [15:0] cw(input int ch, input int cfg, input logic bin, input logic sb);
    return {1'b1, sadc_pkg::TGT_CONTROL, 3'(ch), 2'(cfg), bin, 1'b0, sb, 5'h00};
  endfunction : cw

  // Result of this frame is sent by the next one
  task automatic xfer(input logic [15:0] wr, input logic [12:0] code, input logic known);
    logic [15:0] rd;
    int          d0;
    d0 = dones;
    conv_code = code;
    sadc_host_model_i.frame(wr, 16, rd);
    if (pend_ok) chk("result word", pend, rd);
    pend = {3'(cur_ch), code[12] ^ cur_bin, code[11:0]};
    pend_ok = known;
    repeat (16) @(negedge core_clk);
    chk("conversions", 16'(d0 + 1), 16'(dones));
  endtask : xfer

  // ****
  // Scenarios
  // ****
  task automatic t_config;
    xfer({1'b1, sadc_pkg::TGT_RANGE_LO, 5'h00, 8'he4}, 13'h1a5c, 1'b1);
    xfer({1'b1, sadc_pkg::TGT_RANGE_HI, 5'h00, 8'he4}, 13'h0123, 1'b1);
    for (int cfg = 0; cfg < 4; cfg++) begin
      xfer(cw(cfg * 2 + 1, cfg, 1'b0, 1'b0), {cfg[0], 12'ha5f ^ 12'(cfg)}, 1'b1);
      cur_ch = cfg * 2 + 1;
      chk("channel", 16'(cur_ch), 16'(mux_sel));
      chk("arrangement", 16'(cfg), 16'(input_config));
      chk("range", 16'(cur_ch % 4), 16'(range_sel));
    end
  endtask : t_config

  task automatic t_coding;
    xfer(cw(2, 0, 1'b1, 1'b0), 13'h0777, 1'b0);
    cur_ch = 2;
    cur_bin = 1'b1;
    xfer(16'h0000, 13'h1234, 1'b1);
    xfer(cw(2, 0, 1'b0, 1'b0), 13'h0fff, 1'b0);
    cur_bin = 1'b0;
  endtask : t_coding

  task automatic t_abort;
    logic [15:0] rd;
    int          d0;
    d0 = dones;
    sadc_host_model_i.frame(cw(6, 1, 1'b0, 1'b0), 8, rd);
    repeat (3) @(negedge core_clk);
    chk("output enable", 16'h0, 16'(dout_oe));
    repeat (16) @(negedge core_clk);
    chk("conversions", 16'(d0), 16'(dones));
    chk("channel", 16'h2, 16'(mux_sel));
    pend_ok = 1'b0;
  endtask : t_abort

  task automatic t_quiet;
    logic [15:0] rd;
    int          q0;
    q0 = qerrs;
    sadc_host_model_i.frame(16'h0000, 16, rd);
    sadc_host_model_i.pulse(3);
    repeat (16) @(negedge core_clk);
    chk("quiet faults", 16'(q0 + 1), 16'(qerrs));
  endtask : t_quiet

  task automatic t_standby;
    logic [15:0] rd;
    int          n;
    n = 0;
    xfer(cw(2, 0, 1'b0, 1'b1), 13'h0555, 1'b1);
    chk("power", 16'h1, 16'(power_up));
    // Standby takes hold at the end of the first frame after the write
    xfer(16'h0000, 13'h0aaa, 1'b1);
    chk("power", 16'h0, 16'(power_up));
    fork
      sadc_host_model_i.frame(cw(2, 0, 1'b0, 1'b0), 16, rd);
      begin
        @(negedge cs_n);
        while (power_up !== 1'b1 && n < 400) begin
          @(negedge core_clk);
          n++;
        end
      end
    join
    chk("result word", pend, rd);
    chk("wake in time", 16'(n <= sadc_pkg::WAKE_CYC + 1), 16'h1);
    sadc_host_model_i.frame(16'h0000, 16, rd);
    repeat (300) @(negedge core_clk);
    chk("power", 16'h1, 16'(power_up));
    pend_ok = 1'b0;
  endtask : t_standby

  // Sequencer: mask picks channels 2 and 5, start at 5
  task automatic t_sequence;
    xfer({1'b1, sadc_pkg::TGT_SEQUENCE, 3'h5, 2'h0, 8'h24}, 13'h0321, 1'b1);
    chk("channel", 16'h2, 16'(mux_sel));
    xfer({1'b1, sadc_pkg::TGT_CONTROL, 3'h0, 2'h0, 1'b0, 1'b1, 1'b0, 5'h00}, 13'h0654, 1'b1);
    cur_ch = 5;
    chk("channel", 16'h5, 16'(mux_sel));
    xfer(16'h0000, 13'h1987, 1'b1);
    cur_ch = 2;
    chk("channel", 16'h2, 16'(mux_sel));
    xfer(cw(2, 0, 1'b0, 1'b0), 13'h0abc, 1'b1);
    chk("channel", 16'h2, 16'(mux_sel));
  endtask : t_sequence

  // Held frames add a word each until the buffer refuses
  task automatic t_full;
    logic [15:0] rd;
    int          n;
    int          h0;
    n = 0;
    xfer(16'h0000, 13'h1c3a, 1'b1);
    read_hold = 1'b1;
    while (result_full !== 1'b1 && n < 10) begin
      sadc_host_model_i.frame(16'h0000, 16, rd);
      chk("held word", pend, rd);
      repeat (16) @(negedge core_clk);
      n++;
    end
    chk("frames to fill", 16'h7, 16'(n));
    h0 = holds;
    n = dones;
    sadc_host_model_i.frame(16'h0000, 16, rd);
    repeat (16) @(negedge core_clk);
    chk("holds when full", 16'(h0), 16'(holds));
    chk("conversions", 16'(n), 16'(dones));
    read_hold = 1'b0;
  endtask : t_full

  initial begin
    repeat (10) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (2) @(negedge core_clk);
    chk("output enable", 16'h0, 16'(dout_oe));
    chk("power", 16'h1, 16'(power_up));
    chk("channel", 16'h0, 16'(mux_sel));
    chk("buffer full", 16'h0, 16'(result_full));
    t_config();
    t_coding();
    t_abort();
    t_quiet();
    t_standby();
    t_sequence();
    t_full();
    final_report();
  end

  initial begin
    #100us;
    fails++;
    final_report();
  end
endmodule : test_sadc_host_if

bind sadc_host_if sadc_host_if_checker sadc_host_if_checker_i (.core_clk(core_clk),
  .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .dout(dout), .dout_oe(dout_oe),
  .hold_en(hold_en), .mux_sel(mux_sel), .power_up(power_up), .conv_done(conv_done),
  .quiet_err(quiet_err));
